// ### logic/ebw_host.v
// Host controller driving a byte-wide electrically erasable memory
// over its parallel pins, with busy watched on the completion line.
// Assumes pins connect directly to one or more wired-OR devices.
// A write completes on a seen fall and then rise of the busy line, or ends on the watchdog timeout.
// Functional notes
// RULE_01: Device holds 2K bytes, addressed bytewise over parallel bus.
// RULE_02: Host selects chip, then pulses write strobe low for 100 ns.
// RULE_03: Device latches address, data, strobe; host bus freed meanwhile.
// RULE_04: Device pulls busy low at write start, releases when done.
// RULE_05: Device leaves the bus while writing.
// RULE_06: Device reads byte internally first to decide on erase.
// RULE_07: Any zero bit: erase up to 5 ms, then write up to 5 ms.
// RULE_08: All ones: skip erase, write only, up to 5 ms.
// RULE_09: Busy rises only after verified completion; usable as interrupt.
// RULE_10: Host waits on busy line, not a fixed delay.
// RULE_11: Busy is open drain; wired-OR busy lasts until slowest finishes.
// RULE_12: Device blocks spurious writes during supply ramps.
// RULE_13: Host drives select, read and write strobes; busy may interrupt.
// RULE_14: Device ignores strobes and reads while busy is low.
`include "ebw_defs.vh"
module ebw_host #(
  parameter ADDR_W = `EBW_ADDR_W,
  parameter DATA_W = `EBW_DATA_W,
  parameter TMAX_CYC = `EBW_TMAX_CYC
) (
  input wire ref_clk,
  input wire rstn,
  input wire req_valid,
  input wire req_write,
  input wire [ADDR_W-1:0] req_addr,
  input wire [DATA_W-1:0] req_wdata,
  output wire req_ready,
  output reg rsp_valid_q,
  output reg [DATA_W-1:0] rsp_rdata_q,
  output reg rsp_timeout_q,
  output wire busy,
  output wire write_done,
  output reg chip_select_n_q,
  output reg output_drive_n_q,
  output reg write_strobe_n_q,
  output reg [ADDR_W-1:0] addr_q,
  input wire [DATA_W-1:0] data_in,
  output reg [DATA_W-1:0] data_out_q,
  output reg data_oe_q,
  input wire write_in_progress_in
);
  // Sequencer states
  localparam S_IDLE = 3'd0;
  localparam S_SETUP = 3'd1;
  localparam S_STROBE = 3'd2;
  localparam S_SETTLE = 3'd3;
  localparam S_BUSY = 3'd4;
  localparam S_READ = 3'd5;
  localparam integer WE_CYC_I = `EBW_WE_CYC;
  localparam integer CS_CYC_I = `EBW_CS_SETUP_CYC;
  localparam integer RD_CYC_I = `EBW_RD_CYC;
  localparam integer BW_CYC_I = `EBW_BUSY_WAIT_CYC;
  // Counts fit one byte; cut to the counter width on purpose
  localparam [7:0] WE_CYC = WE_CYC_I[7:0];
  localparam [7:0] CS_CYC = CS_CYC_I[7:0];
  localparam [7:0] RD_CYC = RD_CYC_I[7:0];
  localparam [7:0] BW_CYC = BW_CYC_I[7:0];

  reg [2:0] state_q;
  reg [7:0] cnt_q;
  reg [31:0] wd_q;
  reg done_q;
  reg low_seen_q;
  wire rdy_s;
  wire [DATA_W-1:0] data_s;
  genvar gi;

  // Counter reaches its limit on this cycle
  function cnt_hit;
    input [7:0] cnt;
    input [7:0] lim;
    begin
      cnt_hit = (cnt + 8'h01 >= lim);
    end
  endfunction

  // Line is low while any device on the wire is busy
  ebw_sync #(.RESET_VAL(1'b1)) u_sync (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .async_in(write_in_progress_in),
    .sync_q(rdy_s)
  );

  // Read bus passes two flops; the read wait covers their delay
  generate
    for (gi = 0; gi < DATA_W; gi = gi + 1) begin : g_dsync
      ebw_sync #(.RESET_VAL(1'b0)) u_dsync (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .async_in(data_in[gi]),
        .sync_q(data_s[gi])
      );
    end
  endgenerate

  // No new cycle while any shared device is still programming
  assign req_ready = (state_q == S_IDLE) && rdy_s; // RULE_14 RULE_11
  assign busy = (state_q != S_IDLE) || !rdy_s;
  assign write_done = done_q; // RULE_09

  // A line stuck during S_BUSY ends in a timeout, never a hang
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wd_q <= 32'h0;
    end else if (state_q == S_BUSY) begin
      wd_q <= wd_q + 32'h1;
    end else begin
      wd_q <= 32'h0;
    end
  end

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= S_IDLE;
      cnt_q <= 8'h00;
      low_seen_q <= 1'b0;
      done_q <= 1'b0;
      rsp_valid_q <= 1'b0;
      rsp_rdata_q <= {DATA_W{1'b0}};
      rsp_timeout_q <= 1'b0;
      chip_select_n_q <= 1'b1;
      output_drive_n_q <= 1'b1;
      write_strobe_n_q <= 1'b1;
      addr_q <= {ADDR_W{1'b0}};
      data_out_q <= {DATA_W{1'b0}};
      data_oe_q <= 1'b0;
    end else begin
      rsp_valid_q <= 1'b0;
      done_q <= 1'b0;
      case (state_q)
        S_IDLE: begin
          // Timeout flag stands until the next idle cycle
          rsp_timeout_q <= 1'b0;
          low_seen_q <= 1'b0;
          if (req_valid && rdy_s) begin
            addr_q <= req_addr; // RULE_01
            chip_select_n_q <= 1'b0; // RULE_13
            cnt_q <= 8'h00;
            if (req_write) begin
              data_out_q <= req_wdata;
              data_oe_q <= 1'b1;
              state_q <= S_SETUP;
            end else begin
              output_drive_n_q <= 1'b0; // RULE_13
              state_q <= S_READ;
            end
          end
        end
        S_SETUP: begin
          // Select settles before the strobe falls
          if (cnt_hit(cnt_q, CS_CYC)) begin
            write_strobe_n_q <= 1'b0; // RULE_02
            cnt_q <= 8'h00;
            state_q <= S_STROBE;
          end else begin
            cnt_q <= cnt_q + 8'h01;
          end
        end
        S_STROBE: begin
          // Strobe held low for the full pulse width
          if (cnt_hit(cnt_q, WE_CYC)) begin
            write_strobe_n_q <= 1'b1; // RULE_02
            cnt_q <= 8'h00;
            state_q <= S_SETTLE;
          end else begin
            cnt_q <= cnt_q + 8'h01;
          end
        end
        S_SETTLE: begin
          // Device has latched everything; free the bus
          chip_select_n_q <= 1'b1; // RULE_03
          data_oe_q <= 1'b0;
          // Line may already fall while settling
          if (!rdy_s) begin
            low_seen_q <= 1'b1;
          end
          if (cnt_hit(cnt_q, BW_CYC)) begin
            state_q <= S_BUSY;
          end else begin
            cnt_q <= cnt_q + 8'h01;
          end
        end
        S_BUSY: begin
          // Completion is a rise of the line, so its fall must be seen
          if (!rdy_s) begin
            low_seen_q <= 1'b1;
          end
          if (rdy_s && low_seen_q) begin // RULE_10 RULE_04 RULE_11
            done_q <= 1'b1;
            rsp_valid_q <= 1'b1;
            state_q <= S_IDLE;
          end else if (wd_q + 32'h1 >= TMAX_CYC) begin
            // Watchdog in case the line never releases
            rsp_valid_q <= 1'b1;
            rsp_timeout_q <= 1'b1;
            state_q <= S_IDLE;
          end
        end
        S_READ: begin
          // Sample the synced bus and release the strobes on the same edge
          if (cnt_hit(cnt_q, RD_CYC)) begin
            rsp_rdata_q <= data_s;
            rsp_valid_q <= 1'b1;
            output_drive_n_q <= 1'b1;
            chip_select_n_q <= 1'b1;
            state_q <= S_IDLE;
          end else begin
            cnt_q <= cnt_q + 8'h01;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end
endmodule

// ### logic/ebw_defs.vh
// Constants for the host-side byte write controller.
// Assumes a 50 MHz ref_clk and an external 2K x 8 byte-wide memory.
`ifndef EBW_DEFS_VH
`define EBW_DEFS_VH
`define EBW_CLK_MHZ 50
`define EBW_ADDR_W 11
`define EBW_DATA_W 8
`define EBW_DEPTH 2048
// Write strobe width, ns, and its cycle count (least time, rounded up)
`define EBW_WE_NS 100
`define EBW_WE_CYC ((`EBW_WE_NS * `EBW_CLK_MHZ + 999) / 1000)
// Chip select setup before strobe, in cycles
`define EBW_CS_SETUP_CYC 1
// Read strobe to data sample, in cycles
`define EBW_RD_CYC 4
// Busy watchdog: erase 5 ms plus write 5 ms, in ms and cycles
`define EBW_TMAX_MS 10
`define EBW_TMAX_CYC (`EBW_TMAX_MS * `EBW_CLK_MHZ * 1000)
// Cycles after strobe before busy is trusted
`define EBW_BUSY_WAIT_CYC 4
`endif

// ### logic/ebw_sync.v
// Two-flop synchroniser for a single level from a pin.
// Assumes the input is asynchronous to ref_clk.
module ebw_sync #(
  parameter RESET_VAL = 1'b1
) (
  input wire ref_clk,
  input wire rstn,
  input wire async_in,
  output reg sync_q
);
  reg meta_q;
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= RESET_VAL;
      sync_q <= RESET_VAL;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end
endmodule

// ### verif/ebw_sva.sv
// Pin timing checks for ebw_host.
// Assumes a bind onto ebw_host; 5 ref_clk cycles make 100 ns.
module ebw_sva (
  input logic ref_clk,
  input logic rstn,
  input logic req_ready,
  input logic chip_select_n_q,
  input logic output_drive_n_q,
  input logic write_strobe_n_q,
  input logic write_in_progress_in
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  a_strobe_width: assert property (
    $fell(write_strobe_n_q) |-> !write_strobe_n_q[*5] ##1 write_strobe_n_q)
    else $error("write strobe width wrong");
  a_select_setup: assert property (
    !write_strobe_n_q |-> !chip_select_n_q && !$past(chip_select_n_q))
    else $error("select not set up before strobe");
  a_strobe_excl: assert property (
    !output_drive_n_q |-> write_strobe_n_q && !chip_select_n_q)
    else $error("read strobe clash");
  a_wait_line: assert property (
    !write_in_progress_in[*3] |-> !req_ready)
    else $error("ready while line low");
endmodule

// ### verif/ebw_mem_model.sv
// Behavioural 2K x 8 byte-wide memory with self-timed writes.
// Assumes the host pins of ebw_host; no clock of its own.
// Write time sits off the 20 ns grid so the line never rises on an edge.
module ebw_mem_model #(parameter int ER_NS = 400, WR_NS = 205) (
  input logic rstn,
  input logic cs_n,
  input logic oe_n,
  input logic we_n,
  input logic [10:0] addr,
  input logic [7:0] din,
  output logic [7:0] dout,
  output logic rdy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:2047];
  logic [10:0] la;
  logic [7:0] ld;
  initial begin
    rdy = 1;
    foreach (mem[i]) mem[i] = 8'hff;
  end
  // Inverted junk when off the bus, so a stale sample shows
  assign dout = (!cs_n && !oe_n && rdy) ? mem[addr] : ~mem[addr];
  // Blocked in delays while busy, so later strobes are lost
  always @(posedge we_n) if (rstn && !cs_n) begin
    la = addr;
    ld = din;
    rdy = 0;
    if (mem[la] !== 8'hff) #ER_NS mem[la] = 8'hff;
    #WR_NS mem[la] = ld;
    rdy = 1;
  end
endmodule

// ### verif/test_ebw_host.sv
// Self-checking bench for ebw_host against a memory model.
// Assumes a 50 MHz ref_clk and a pull-up on the busy line.
module test_ebw_host;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 0, rstn = 0, req_valid = 0, req_write = 0;
  logic [10:0] req_addr = 0, addr_q;
  logic [7:0] req_wdata = 0, rsp_rdata_q, data_out_q, dev_q, data_in;
  logic req_ready, rsp_valid_q, rsp_timeout_q, busy, write_done, data_oe_q;
  logic chip_select_n_q, output_drive_n_q, write_strobe_n_q;
  logic write_in_progress_in, mem_rdy, other_rdy = 1;
  int fails = 0, checks = 0, cyc = 0, n1, n2;
  always #10 ref_clk = ~ref_clk;
  assign data_in = data_oe_q ? data_out_q : dev_q;
  // Busy line shared with a second device, wired-OR low
  assign write_in_progress_in = mem_rdy & other_rdy;
  ebw_host #(.TMAX_CYC(200)) dut_u (.ref_clk(ref_clk), .rstn(rstn),
    .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid_q(rsp_valid_q),
    .rsp_rdata_q(rsp_rdata_q), .rsp_timeout_q(rsp_timeout_q), .busy(busy),
    .write_done(write_done), .chip_select_n_q(chip_select_n_q),
    .output_drive_n_q(output_drive_n_q),
    .write_strobe_n_q(write_strobe_n_q), .addr_q(addr_q),
    .data_in(data_in), .data_out_q(data_out_q), .data_oe_q(data_oe_q),
    .write_in_progress_in(write_in_progress_in));
  ebw_mem_model mem_u (.rstn(rstn), .cs_n(chip_select_n_q),
    .oe_n(output_drive_n_q), .we_n(write_strobe_n_q), .addr(addr_q),
    .din(data_out_q), .dout(dev_q), .rdy(mem_rdy));
  task chk(input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task req(input logic w, input logic [10:0] a, input logic [7:0] d,
    output int n);
    n = 0;
    while (req_ready !== 1'b1) @(posedge ref_clk) #1;
    {req_write, req_addr, req_wdata, req_valid} = {w, a, d, 1'b1};
    @(posedge ref_clk) #1 req_valid = 0;
    while (rsp_valid_q !== 1'b1 && n < 3000) @(posedge ref_clk) #1 n++;
    chk(n < 3000, 1);
  endtask
  task t_erase;
    req(1, 11'h7ff, 8'h5a, n1);
    chk(write_done, 1);
    chk(rsp_timeout_q, 0);
    chk(busy, 0);
    chk({chip_select_n_q, write_strobe_n_q}, 2'b11);
    chk({output_drive_n_q, data_oe_q}, 2'b10);
    req(1, 11'h7ff, 8'h3c, n2);
    chk(n2 - n1, 20);
    req(0, 11'h7ff, 8'h00, n1);
    chk(rsp_rdata_q, 8'h3c);
    $display("t_erase done");
  endtask
  task t_edge;
    req(1, 11'h000, 8'h00, n1);
    req(0, 11'h000, 8'hff, n1);
    chk(rsp_rdata_q, 8'h00);
    req(0, 11'h001, 8'h00, n1);
    chk(rsp_rdata_q, 8'hff);
    $display("t_edge done");
  endtask
  task t_wired;
    other_rdy = 0;
    repeat (3) @(posedge ref_clk);
    #1 chk(req_ready, 0);
    chk(busy, 1);
    other_rdy = 1;
    fork
      req(1, 11'h020, 8'h22, n1);
      begin
        @(negedge write_strobe_n_q) #1 other_rdy = 0;
        repeat (60) @(posedge ref_clk);
        #1 other_rdy = 1;
      end
    join
    chk(n1 >= 60, 1);
    chk(write_done, 1);
    fork
      begin
        req(1, 11'h030, 8'h33, n1);
        chk(rsp_timeout_q, 1);
        chk(write_done, 0);
      end
      begin
        @(negedge write_strobe_n_q) #1 other_rdy = 0;
        repeat (250) @(posedge ref_clk);
        #1 other_rdy = 1;
      end
    join
    req(0, 11'h030, 8'h00, n1);
    chk(rsp_rdata_q, 8'h33);
    $display("t_wired done");
  endtask
  task print_verdict;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge ref_clk) if (++cyc == 20000) begin
    fails++;
    print_verdict;
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    #1 rstn = 1;
    t_erase;
    t_edge;
    t_wired;
    print_verdict;
  end
endmodule
bind ebw_host ebw_sva chk_u (.ref_clk(ref_clk), .rstn(rstn),
  .req_ready(req_ready), .chip_select_n_q(chip_select_n_q),
  .output_drive_n_q(output_drive_n_q), .write_strobe_n_q(write_strobe_n_q),
  .write_in_progress_in(write_in_progress_in));
